// file: rtl/cap_pkg.sv
// package for the counter array capture / 8-bit width modulation module
package cap_pkg;
   // register word offsets on the avalon bus (byte addresses)
   localparam logic [4:0] OFS_CTRL = 5'h00;    // array_control_reg
   localparam logic [4:0] OFS_MODE = 5'h04;    // module_mode_reg
   localparam logic [4:0] OFS_CMPL = 5'h08;    // compare_low_byte / capture low
   localparam logic [4:0] OFS_CMPH = 5'h0C;    // compare_high_byte / capture high
   localparam logic [4:0] OFS_CNT = 5'h10;     // shared counter, read only
   localparam logic [4:0] OFS_IRQ_STAT = 5'h14; // sticky status, read only
   localparam logic [4:0] OFS_IRQ_CLR = 5'h18;  // write one to clear
   localparam logic [4:0] OFS_IRQ_EN = 5'h1C;   // enable
   // array_control_reg fields
   localparam int CTRL_EVT_BIT = 0;   // module_event_flag
   localparam int CTRL_RUN_BIT = 1;   // counter run
   localparam int CTRL_IRQEN_BIT = 2; // array_irq_enable
   localparam int CTRL_PIN_BIT = 3;   // synchronised pin level, read only
   // module_mode_reg fields
   localparam int MODE_WMS_BIT = 1;   // width_mod_select
   localparam int MODE_MFE_BIT = 3;   // match_flag_enable
   localparam int MODE_CFALL_BIT = 4; // capture_on_fall
   localparam int MODE_CRISE_BIT = 5; // capture_on_rise
   localparam int MODE_CEN_BIT = 6;   // comparator_enable
   // status register bits
   localparam int ST_CAP_BIT = 0;
   localparam int ST_MATCH_BIT = 1;
   localparam int ST_OVF_BIT = 2;
   // reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [15:0] CNT_RST = 16'h0000;
   localparam logic [7:0] LOW_MAX = 8'hFF;
   localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;
   // least pin hold in system clocks
   localparam int PIN_HOLD_CYC = 2;
endpackage

// file: rtl/cap_pin_sync.sv
// two-stage synchroniser and edge detector for the module pin
`timescale 1ns/1ps
module cap_pin_sync (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic pin_i,
   output logic level_o,
   output logic rise_o,
   output logic fall_o
);
   logic meta_r;
   logic sync_r;
   logic prev_r;

   // first stage feeds only the second; edges compare settled samples
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         prev_r <= 1'b0;
      end else begin
         meta_r <= pin_i;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   assign level_o = sync_r;
   assign rise_o = sync_r & ~prev_r;
   assign fall_o = ~sync_r & prev_r;
endmodule // cap_pin_sync

// file: rtl/cap_module.sv
// capture and 8-bit width modulation module with avalon register slave
//
// Function
// - a qualifying pin edge copies the 16-bit counter into the capture pair
// - rise and fall select bits choose rising, falling or either edge
// - every capture sets the module event flag
// - a set event flag with interrupts enabled raises the request
// - only a software write clears the event flag, never servicing
// - pin level stays readable so software can tell the edge
// - pin levels shorter than two clocks may be missed
// - in width mode the pin goes high on low byte match
// - in width mode the pin goes low on low byte overflow unless compare high is zero
// - in width mode, on low byte rollover the compare low reloads from compare high
// - width mode needs comparator enable and width select both set
// - with match flag enable, each width match sets the event flag
// - writing low byte clears comparator enable, high byte sets it
// - high fraction is 256 minus compare high over 256
// - comparator enable clear holds the pin output at zero
// - one array interrupt enable gates the array request; irq_o is gated by the enable register
`timescale 1ns/1ps
module cap_module (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic [4:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic module_io_pin_i,
   output logic module_io_pin_o,
   output logic module_io_pin_oe_o,
   output logic irq_o,
   output logic array_irq_o
);
   ////////////////////////////////////////////////////////////////////////////
   // declarations
   logic [7:0] ctrl_r;
   logic [7:0] mode_r;
   logic [7:0] cmp_low_r;
   logic [7:0] cmp_high_r;
   logic [15:0] cnt_r;
   logic [2:0] irq_stat_r;
   logic [2:0] irq_en_r;
   logic pwm_r;
   logic ack_r;
   logic pin_lvl;
   logic pin_rise;
   logic pin_fall;
   logic wr_hit;
   logic wr_ctrl;
   logic wr_mode;
   logic wr_cmpl;
   logic wr_cmph;
   logic wr_clr;
   logic wr_en;
   logic pwm_mode;
   logic cap_evt;
   logic match_evt;
   logic ovf_evt;
   logic evt_set;
   logic [7:0] cnt_low_nxt;

   // true when a bus write to this offset with byte lane 0 takes effect
   function automatic logic wr_sel(input logic [4:0] a, input logic [4:0] ofs, input logic be0, input logic hit);
      return hit && (a == ofs) && be0;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // pin synchroniser
   cap_pin_sync u_sync (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .pin_i(module_io_pin_i),
      .level_o(pin_lvl),
      .rise_o(pin_rise),
      .fall_o(pin_fall)
   );

   ////////////////////////////////////////////////////////////////////////////
   // avalon slave: one wait cycle, then the access completes
   // waitrequest is high by default and drops for one cycle per access
   // a request raised again right after its answer is simply taken as a new one
   assign wr_hit = avs_write_i && ack_r;
   assign wr_ctrl = wr_sel(avs_address_i, cap_pkg::OFS_CTRL, avs_byteenable_i[0], wr_hit);
   assign wr_mode = wr_sel(avs_address_i, cap_pkg::OFS_MODE, avs_byteenable_i[0], wr_hit);
   assign wr_cmpl = wr_sel(avs_address_i, cap_pkg::OFS_CMPL, avs_byteenable_i[0], wr_hit);
   assign wr_cmph = wr_sel(avs_address_i, cap_pkg::OFS_CMPH, avs_byteenable_i[0], wr_hit);
   assign wr_clr = wr_sel(avs_address_i, cap_pkg::OFS_IRQ_CLR, avs_byteenable_i[0], wr_hit);
   assign wr_en = wr_sel(avs_address_i, cap_pkg::OFS_IRQ_EN, avs_byteenable_i[0], wr_hit);

   // ack toggles so each request sees exactly one low waitrequest edge
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= (avs_read_i || avs_write_i) && !ack_r;
      end
   end
   // waitrequest is a flop of its own so the bus sees a clean registered level
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         avs_waitrequest_o <= 1'b1;
      end else begin
         avs_waitrequest_o <= !((avs_read_i || avs_write_i) && !ack_r);
      end
   end

   // read data is registered while waitrequest is still high
   // so it already stands at the edge where the master sees waitrequest low
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         avs_readdata_o <= cap_pkg::UNMAPPED_RD;
      end else if (avs_read_i && !ack_r) begin
         unique case (avs_address_i)
            cap_pkg::OFS_CTRL: avs_readdata_o <= {24'h0, ctrl_r[7:4], pin_lvl, ctrl_r[2:0]};
            cap_pkg::OFS_MODE: avs_readdata_o <= {24'h0, mode_r};
            cap_pkg::OFS_CMPL: avs_readdata_o <= {24'h0, cmp_low_r};
            cap_pkg::OFS_CMPH: avs_readdata_o <= {24'h0, cmp_high_r};
            cap_pkg::OFS_CNT: avs_readdata_o <= {16'h0, cnt_r};
            cap_pkg::OFS_IRQ_STAT: avs_readdata_o <= {29'h0, irq_stat_r};
            cap_pkg::OFS_IRQ_EN: avs_readdata_o <= {29'h0, irq_en_r};
            default: avs_readdata_o <= cap_pkg::UNMAPPED_RD; // unmapped and write-only read zero
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // shared counter
   // the low byte drives both the width compare and the reload
   assign cnt_low_nxt = cnt_r[7:0] + 8'h01;

   // free-running while the run bit is set; wraps from all ones to zero
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_r <= cap_pkg::CNT_RST;
      end else if (ctrl_r[cap_pkg::CTRL_RUN_BIT]) begin
         cnt_r <= cnt_r + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // events
   assign pwm_mode = mode_r[cap_pkg::MODE_CEN_BIT] && mode_r[cap_pkg::MODE_WMS_BIT];
   assign cap_evt = !pwm_mode && ((pin_rise && mode_r[cap_pkg::MODE_CRISE_BIT])
                    || (pin_fall && mode_r[cap_pkg::MODE_CFALL_BIT]));
   assign ovf_evt = ctrl_r[cap_pkg::CTRL_RUN_BIT] && (cnt_r[7:0] == cap_pkg::LOW_MAX);
   // match looks one count ahead so the registered output rises as the
   // counter reaches the compare value; only a running counter can match,
   // which also makes the match flag fire once per period, not every cycle
   assign match_evt = pwm_mode && ctrl_r[cap_pkg::CTRL_RUN_BIT] && (cnt_low_nxt == cmp_low_r);
   assign evt_set = cap_evt || (match_evt && mode_r[cap_pkg::MODE_MFE_BIT]);

   ////////////////////////////////////////////////////////////////////////////
   // array_control_reg: event flag set wins over a software clear
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl_r <= cap_pkg::CTRL_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl_r <= avs_writedata_i[7:0] & 8'h07;
         end
         if (evt_set) begin
            ctrl_r[cap_pkg::CTRL_EVT_BIT] <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // module_mode_reg: compare byte writes steer comparator enable
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         mode_r <= cap_pkg::MODE_RST;
      end else if (wr_mode) begin
         mode_r <= avs_writedata_i[7:0];
      end else if (wr_cmpl) begin
         mode_r[cap_pkg::MODE_CEN_BIT] <= 1'b0;
      end else if (wr_cmph) begin
         mode_r[cap_pkg::MODE_CEN_BIT] <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // capture pair / compare bytes
   // a capture outranks a software write in the same cycle
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cmp_low_r <= 8'h00;
         cmp_high_r <= 8'h00;
      end else if (cap_evt) begin
         cmp_low_r <= cnt_r[7:0];
         cmp_high_r <= cnt_r[15:8];
      end else begin
         if (wr_cmph) begin
            cmp_high_r <= avs_writedata_i[7:0];
         end
         if (wr_cmpl) begin
            cmp_low_r <= avs_writedata_i[7:0];
         end else if (pwm_mode && ovf_evt) begin
            cmp_low_r <= cmp_high_r;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // width-modulated output; high fraction (256 - high)/256
   // follows: reload at rollover, set at match, clear at next rollover
   // the flop is set one edge early so it is high exactly while the counter
   // shows the compare value up to 0xFF; a compare of 0xFF gives one cycle
   // limitation: a compare high written mid-period only counts from the next rollover
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pwm_r <= 1'b0;
      end else if (!mode_r[cap_pkg::MODE_CEN_BIT]) begin
         pwm_r <= 1'b0;
      end else if (!pwm_mode) begin
         pwm_r <= 1'b0;
      end else if (ovf_evt) begin
         pwm_r <= (cmp_high_r == 8'h00);
      end else if (match_evt) begin
         pwm_r <= 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         module_io_pin_o <= 1'b0;
         module_io_pin_oe_o <= 1'b0;
      end else begin
         module_io_pin_o <= pwm_r;
         module_io_pin_oe_o <= pwm_mode;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sticky status, enable and clear; set wins over clear
   // an event in the cycle of its own clear is kept, so none is lost
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         irq_stat_r <= 3'h0;
         irq_en_r <= 3'h0;
      end else begin
         irq_stat_r <= (irq_stat_r & ~({3{wr_clr}} & avs_writedata_i[2:0]))
                       | {ovf_evt, match_evt, cap_evt};
         if (wr_en) begin
            irq_en_r <= avs_writedata_i[2:0];
         end
      end
   end

   // the array request follows the flag, gated by the one array enable
   // both requests are registered, so they trail their cause by one clock
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         irq_o <= 1'b0;
         array_irq_o <= 1'b0;
      end else begin
         irq_o <= |(irq_stat_r & irq_en_r);
         array_irq_o <= ctrl_r[cap_pkg::CTRL_EVT_BIT] && ctrl_r[cap_pkg::CTRL_IRQEN_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // assertions
   chk_cap_latch: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      cap_evt |=> (cmp_low_r == $past(cnt_r[7:0]) && cmp_high_r == $past(cnt_r[15:8])))
      else $error("capture pair did not take counter");
   chk_edge_select: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (cap_evt |-> ((pin_rise && mode_r[5]) || (pin_fall && mode_r[4]))))
      else $error("capture on unselected edge");
   chk_flag_set: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      evt_set |=> ctrl_r[0])
      else $error("event flag not set");
   chk_irq_raise: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (ctrl_r[0] && ctrl_r[2]) |=> array_irq_o)
      else $error("interrupt request missing");
   chk_flag_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (ctrl_r[0] && !wr_ctrl) |=> ctrl_r[0])
      else $error("event flag lost without write");
   chk_pin_readback: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      avs_read_i && !ack_r && avs_address_i == cap_pkg::OFS_CTRL |=> avs_readdata_o[3] == $past(pin_lvl))
      else $error("pin level not readable");
   chk_pwm_high: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (match_evt && !ovf_evt) |=> ##1 module_io_pin_o)
      else $error("pin not set on match");
   chk_pwm_low: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (pwm_mode && ovf_evt && cmp_high_r != 8'h00 && !wr_mode) |=> ##1 !module_io_pin_o)
      else $error("pin not cleared on overflow");
   chk_reload: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (pwm_mode && ovf_evt && !wr_cmpl) |=> cmp_low_r == $past(cmp_high_r))
      else $error("compare low not reloaded");
   chk_cen_write: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      wr_cmph |=> mode_r[6])
      else $error("high write did not set enable");
   chk_zero_duty: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      !mode_r[6] [*2] |=> !module_io_pin_o)
      else $error("output high with comparator off");
   chk_cnt_step: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ctrl_r[1] |=> cnt_r == $past(cnt_r) + 16'h0001)
      else $error("counter did not step");

   // capture pair, edge choice, request gating, pin ownership and compare writes
   chk_cap_idle: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (!cap_evt && !wr_cmpl && !(pwm_mode && ovf_evt)) |=> $stable(cmp_low_r))
      else $error("capture low changed with no cause");
   chk_rise_select: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (pin_rise && mode_r[cap_pkg::MODE_CRISE_BIT] && !pwm_mode) |-> cap_evt)
      else $error("selected rising edge not captured");
   chk_fall_select: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (pin_fall && mode_r[cap_pkg::MODE_CFALL_BIT] && !pwm_mode) |-> cap_evt)
      else $error("selected falling edge not captured");
   chk_irq_drop: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      !ctrl_r[cap_pkg::CTRL_EVT_BIT] |=> !array_irq_o)
      else $error("request without event flag");
   chk_irq_gate: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      !ctrl_r[cap_pkg::CTRL_IRQEN_BIT] |=> !array_irq_o)
      else $error("request with array enable off");
   chk_oe_on: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      pwm_mode |=> module_io_pin_oe_o)
      else $error("width mode does not drive pin");
   chk_oe_off: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      !pwm_mode |=> !module_io_pin_oe_o)
      else $error("pin driven outside width mode");
   chk_cen_clear: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      wr_cmpl |=> !mode_r[cap_pkg::MODE_CEN_BIT])
      else $error("low write did not clear enable");
   chk_match_flag: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (match_evt && mode_r[cap_pkg::MODE_MFE_BIT]) |=> ctrl_r[cap_pkg::CTRL_EVT_BIT])
      else $error("match did not set event flag");
   chk_full_duty: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (pwm_mode && ovf_evt && cmp_high_r == 8'h00) |=> ##1 module_io_pin_o)
      else $error("zero high byte did not hold pin high");

   cov_capture: cover property (@(posedge clk_i) disable iff (!rst_b_i) cap_evt);
   cov_match: cover property (@(posedge clk_i) disable iff (!rst_b_i) match_evt);
   cov_reload: cover property (@(posedge clk_i) disable iff (!rst_b_i) pwm_mode && ovf_evt);
   cov_irq: cover property (@(posedge clk_i) disable iff (!rst_b_i) array_irq_o);
   // a falling capture shows the either-edge or falling-only setting was reached
   cov_fall_capture: cover property (@(posedge clk_i) disable iff (!rst_b_i) cap_evt && pin_fall);
endmodule // cap_module

// file: verification/cap_pin_model.sv
// signal source standing on the far side of the module io pin
`timescale 1ns/1ps
module cap_pin_model (
   input wire logic clk_i,
   input wire logic dev_drv_i,
   input wire logic dev_oe_i,
   output logic pin_o
);
   logic lvl_r = 1'b0;
   // the device owns the line while it drives, else the source level shows
   assign pin_o = dev_oe_i ? dev_drv_i : lvl_r;
   // every level is held two clocks at least, shorter pulses may be lost
   task automatic drive(input logic v, input int hold);
      lvl_r <= v;
      repeat ((hold < 2) ? 2 : hold) @(posedge clk_i);
   endtask
endmodule // cap_pin_model

// file: verification/counter_array_capture_pwm8_tb.sv
// self-checking bench for the capture and width modulation module
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module counter_array_capture_pwm8_tb;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [4:0] avs_address_i = 5'h00;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [3:0] avs_byteenable_i = 4'hF;
   logic [31:0] avs_readdata_o, q, c0, c1, c2;
   logic avs_waitrequest_o, module_io_pin_o, module_io_pin_oe_o, irq_o, array_irq_o, pin_w;
   logic [31:0] exp_q[$], msk_q[$];
   logic [7:0] hb, md;
   int n_errors = 0;
   int n_checks = 0;
   int seed = 32'h92bf;
   int cnt;
   always #5 clk_i = ~clk_i;
   cap_module dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
      .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
      .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .module_io_pin_i(pin_w),
      .module_io_pin_o(module_io_pin_o), .module_io_pin_oe_o(module_io_pin_oe_o), .irq_o(irq_o),
      .array_irq_o(array_irq_o));
   cap_pin_model src (.clk_i(clk_i), .dev_drv_i(module_io_pin_o), .dev_oe_i(module_io_pin_oe_o), .pin_o(pin_w));
   ////////////////////////////////////////////////////////////////////////////
   // read results are compared here against the oldest noted expectation
   always @(posedge clk_i) begin
      if (avs_read_i && avs_waitrequest_o === 1'b0 && exp_q.size() > 0) begin
         `CHK(avs_readdata_o & msk_q[0], exp_q[0])
         void'(exp_q.pop_front());
         void'(msk_q.pop_front());
      end
   end
   task automatic end_of_test();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // one bus access, held until waitrequest is seen low; the extra edge keeps calls apart
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
      int k;
      avs_address_i <= a;
      avs_write_i <= wr;
      avs_read_i <= ~wr;
      avs_writedata_i <= d;
      avs_byteenable_i <= be;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (avs_waitrequest_o !== 1'b0 && k < 40);
      q = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      if (k >= 40) begin
         n_errors++;
         end_of_test();
      end
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'h1);
      repeat (2) @(posedge clk_i);
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
      exp_q.push_back(e);
      msk_q.push_back(m);
      bus(1'b0, a, 32'h0, 4'hF);
   endtask
   // capture pair as one 16-bit value, not noted for comparison
   task automatic capr(output logic [31:0] v);
      bus(1'b0, cap_pkg::OFS_CMPL, 32'h0, 4'hF);
      v[7:0] = q[7:0];
      bus(1'b0, cap_pkg::OFS_CMPH, 32'h0, 4'hF);
      v = {16'h0, q[7:0], v[7:0]};
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge clk_i);
      rst_b_i <= 1'b1;
      @(posedge clk_i);
      // reset values and an unaligned, unmapped address
      rd(cap_pkg::OFS_CTRL, 32'h0, 32'hFFFF_FFFF);
      rd(cap_pkg::OFS_MODE, 32'h0, 32'hFFFF_FFFF);
      rd(cap_pkg::OFS_IRQ_STAT, 32'h0, 32'hFFFF_FFFF);
      rd(5'h02, 32'h0, 32'hFFFF_FFFF);
      // rising only, falling only, then either edge, counter running
      for (int m = 0; m < 3; m++) begin
         md = (m == 0) ? 8'h20 : (m == 1) ? 8'h10 : 8'h30;
         wr(cap_pkg::OFS_MODE, {24'h0, md});
         wr(cap_pkg::OFS_CTRL, 32'h02);
         capr(c0);
         src.drive(1'b1, 20 + int'($unsigned($random(seed)) % 20));
         repeat (6) @(posedge clk_i);
         capr(c1);
         `CHK(c1 !== c0, md[5])
         rd(cap_pkg::OFS_CTRL, {28'h0, 1'b1, 2'b00, md[5]}, 32'h09);
         src.drive(1'b0, 20);
         repeat (6) @(posedge clk_i);
         capr(c2);
         `CHK(c2 !== c1, md[4])
         rd(cap_pkg::OFS_CTRL, {31'h0, md[5] | md[4]}, 32'h09);
      end
      // frozen counter: the capture must equal the counter value
      wr(cap_pkg::OFS_CTRL, 32'h00);
      wr(cap_pkg::OFS_MODE, 32'h20);
      bus(1'b0, cap_pkg::OFS_CNT, 32'h0, 4'hF);
      c0 = {16'h0, q[15:0]};
      src.drive(1'b1, 10);
      repeat (6) @(posedge clk_i);
      capr(c1);
      `CHK(c1, c0)
      // interrupts: sticky status, enable, array gate, refused write, clear
      rd(cap_pkg::OFS_IRQ_STAT, 32'h1, 32'h1);
      `CHK(irq_o, 1'b0)
      wr(cap_pkg::OFS_IRQ_EN, 32'h1);
      `CHK(irq_o, 1'b1)
      wr(cap_pkg::OFS_CTRL, 32'h01);
      `CHK(array_irq_o, 1'b0)
      wr(cap_pkg::OFS_CTRL, 32'h05);
      `CHK(array_irq_o, 1'b1)
      bus(1'b1, cap_pkg::OFS_CTRL, 32'h04, 4'hE);
      repeat (2) @(posedge clk_i);
      `CHK(array_irq_o, 1'b1)
      wr(cap_pkg::OFS_CTRL, 32'h04);
      `CHK(array_irq_o, 1'b0)
      wr(cap_pkg::OFS_IRQ_CLR, 32'h7);
      `CHK(irq_o, 1'b0)
      wr(cap_pkg::OFS_IRQ_EN, 32'h0);
      // width mode: any 512 cycles hold exactly two periods of 256
      for (int i = 0; i < 3; i++) begin
         hb = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'h01 + 8'($unsigned($random(seed)) % 254);
         wr(cap_pkg::OFS_MODE, 32'h4A);
         wr(cap_pkg::OFS_CMPL, {24'h0, hb});
         rd(cap_pkg::OFS_MODE, 32'h0A, 32'h4A);
         wr(cap_pkg::OFS_CMPH, {24'h0, hb});
         rd(cap_pkg::OFS_MODE, 32'h4A, 32'h4A);
         wr(cap_pkg::OFS_CTRL, 32'h02);
         repeat (600) @(posedge clk_i);
         cnt = 0;
         repeat (512) begin
            @(posedge clk_i);
            cnt += int'(module_io_pin_o === 1'b1);
         end
         `CHK(cnt, 2 * (256 - int'(hb)))
         `CHK(module_io_pin_oe_o, 1'b1)
         rd(cap_pkg::OFS_CTRL, 32'h1, 32'h1);
         rd(cap_pkg::OFS_IRQ_STAT, 32'h6, 32'h6);
         wr(cap_pkg::OFS_CMPL, {24'h0, hb});
         repeat (300) @(posedge clk_i);
         cnt = 0;
         repeat (512) begin
            @(posedge clk_i);
            cnt += int'(module_io_pin_o === 1'b1);
         end
         `CHK(cnt, 0)
      end
      end_of_test();
   end
endmodule // counter_array_capture_pwm8_tb
